// File: core/scsw_defs.vh
// Offsets, field positions and reset value of the card status word block
`ifndef SCSW_DEFS_VH
`define SCSW_DEFS_VH

// Register byte offsets on the AXI4-Lite bus
`define SCSW_OFF_STATUS   4'h0
`define SCSW_OFF_CTRL     4'h4
`define SCSW_OFF_RESP     4'h8

// Control register fields and reset value
`define SCSW_CTRL_LOCK    0
`define SCSW_CTRL_ECCOFF  1
`define SCSW_CTRL_ST_LO   2
`define SCSW_CTRL_ST_HI   5
`define SCSW_CTRL_RST     32'h0000_0000

// Status word bit positions
`define SCSW_B_LOCKED     25
`define SCSW_B_LOCKFAIL   24
`define SCSW_B_CRCERR     23
`define SCSW_B_ILLEGAL    22
`define SCSW_B_ECCFAIL    21
`define SCSW_B_CTRLFLT    20
`define SCSW_B_GENERIC    19
`define SCSW_B_IDRW       16
`define SCSW_B_WPSKIP     15
`define SCSW_B_ECCOFF     14
`define SCSW_B_ERASERST   13
`define SCSW_B_ST_LO      9
`define SCSW_B_ST_HI      12
`define SCSW_B_RDY        8
`define SCSW_B_SWITCH     7
`define SCSW_B_APP        5
`define SCSW_B_AUTH       3

// Command indices that touch the erase sequence and the prefix flag
`define SCSW_CMD_STATUS   6'h0d
`define SCSW_CMD_ERSTART  6'h23
`define SCSW_CMD_EREND    6'h24
`define SCSW_CMD_ERASE    6'h26
`define SCSW_CMD_APP      6'h37

// AXI response codes
`define SCSW_RESP_OK      2'b00
`define SCSW_RESP_SLVERR  2'b10

`endif

// File: core/scsw_status.v
// Card status word keeper with AXI4-Lite registers and link-side event capture
//
// How it works
// - Bit 25 shows the present lock state, never cleared by a read.
// - Bit 24 sets on lock/unlock sequence or password fault; read clears.
// - Bit 23 sets on command check-code failure; next valid command clears.
// - Bit 22 sets on command illegal for state; next valid command clears.
// - Bit 21 sets on uncorrectable internal correction failure; read clears.
// - Bit 20 flags internal fault unrelated to commands; read clears.
// - Bit 19 flags generic fault during last command execution; read clears.
// - Bit 16 flags id rewrite, spec mismatch or protect reversal; read clears.
// - Bit 15 sets when erase skipped write-protected blocks; read clears.
// - Bit 14 shows correction disabled for the command, follows state.
// - Bit 13 sets when pending erase meets an out-of-sequence command.
// - Bits 12:9 carry the card state captured when the command arrived.
// - A state change by a command shows only in the next response.
// - Bit 8 mirrors the buffer-empty indication from the bus.
// - Bit 7 sets on failed mode switch; next valid command clears.
// - Bit 5 shows an expected application command; read clears.
// - Bit 3 sets on authentication order fault; read clears.
// - Bits 18, 17, 6, 4, 2, 1, 0 carry no function here.
// - The word goes out as a full 32-bit response field.
// - Previous-command bits clear on valid command; read-clear bits on read.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "scsw_defs.vh"

module scsw_status (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Link clock and command decoder events
	input  wire        link_clk,
	input  wire        cmd_valid,
	input  wire [5:0]  cmd_index,
	input  wire        cmd_crc_bad,
	input  wire        cmd_illegal,
	input  wire        lock_unlock_fail,
	input  wire        ecc_fail,
	input  wire        internal_ctrl_fault,
	input  wire        generic_fault,
	input  wire        id_spec_rewrite_fault,
	input  wire        wp_erase_skip,
	input  wire        switch_fail,
	input  wire        auth_seq_fault,
	input  wire        buf_empty,
	// Response word toward the command line
	output reg  [31:0] resp_word,
	output reg         resp_load
);

	localparam NSYNC = 19;

	// Synchronisers for the link clock and all link-side inputs
	reg  [NSYNC-1:0] meta_q;
	reg  [NSYNC-1:0] sync_q;
	reg              lclk_prev_q;
	wire [NSYNC-1:0] raw_in;
	wire             lclk_rise;
	wire             s_cmd;
	wire [5:0]       s_idx;
	wire             s_crc;
	wire             s_ill;
	wire             s_lockf;
	wire             s_eccf;
	wire             s_ctrl;
	wire             s_gen;
	wire             s_idrw;
	wire             s_wps;
	wire             s_sw;
	wire             s_auth;
	wire             s_empty;

	assign raw_in = {link_clk, buf_empty, auth_seq_fault, switch_fail, wp_erase_skip,
		id_spec_rewrite_fault, generic_fault, internal_ctrl_fault, ecc_fail,
		lock_unlock_fail, cmd_illegal, cmd_crc_bad, cmd_index, cmd_valid};

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q      <= {NSYNC{1'b0}};
			sync_q      <= {NSYNC{1'b0}};
			lclk_prev_q <= 1'b0;
		end else begin
			meta_q      <= raw_in;
			sync_q      <= meta_q;
			lclk_prev_q <= sync_q[18];
		end
	end

	assign lclk_rise = sync_q[18] & ~lclk_prev_q;
	assign s_cmd     = sync_q[0];
	assign s_idx     = sync_q[6:1];
	assign s_crc     = sync_q[7];
	assign s_ill     = sync_q[8];
	assign s_lockf   = sync_q[9];
	assign s_eccf    = sync_q[10];
	assign s_ctrl    = sync_q[11];
	assign s_gen     = sync_q[12];
	assign s_idrw    = sync_q[13];
	assign s_wps     = sync_q[14];
	assign s_sw      = sync_q[15];
	assign s_auth    = sync_q[16];
	assign s_empty   = sync_q[17];

	// Events qualified on a link clock rising edge
	wire ev_cmd;
	wire ev_good;
	assign ev_cmd  = lclk_rise & s_cmd;
	assign ev_good = ev_cmd & ~s_crc;

	// Control register and flags
	reg [31:0] ctrl_q;
	reg        lockf_q;
	reg        crc_q;
	reg        ill_q;
	reg        eccf_q;
	reg        ctrl_flt_q;
	reg        gen_q;
	reg        idrw_q;
	reg        wps_q;
	reg        erst_q;
	reg        sw_q;
	reg        app_q;
	reg        auth_q;
	reg        erpend_q;
	reg [3:0]  rx_state_q;
	wire       rd_clear;
	wire       cmd_clear;
	wire       is_status_cmd;
	wire       erase_cmd;
	reg  [31:0] word;

	// Merge a flag: set wins over clear
	function upd;
		input cur;
		input set;
		input clr;
		begin
			upd = set | (cur & ~clr);
		end
	endfunction

	// Byte-lane write merge
	function [31:0] wmerge;
		input [31:0] cur;
		input [31:0] dat;
		input [3:0]  strb;
		integer i;
		begin
			wmerge = cur;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					wmerge[i*8 +: 8] = dat[i*8 +: 8];
				end
			end
		end
	endfunction

	assign is_status_cmd = (s_idx == `SCSW_CMD_STATUS);
	assign erase_cmd = (s_idx == `SCSW_CMD_ERSTART) | (s_idx == `SCSW_CMD_EREND) |
		(s_idx == `SCSW_CMD_ERASE) | is_status_cmd;

	// AXI read handshake of the status register
	wire ar_take;
	wire st_read;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign st_read = ar_take & (s_axi_araddr == `SCSW_OFF_STATUS);

	// read-clear on status command or bus read
	assign rd_clear  = st_read | (ev_good & is_status_cmd);
	assign cmd_clear = ev_good;

	// Assembled status word
	// reserved bits zero
	always @* begin
		word                              = 32'h0000_0000;
		word[`SCSW_B_LOCKED]              = ctrl_q[`SCSW_CTRL_LOCK];
		word[`SCSW_B_LOCKFAIL]            = lockf_q;
		word[`SCSW_B_CRCERR]              = crc_q;
		word[`SCSW_B_ILLEGAL]             = ill_q;
		word[`SCSW_B_ECCFAIL]             = eccf_q;
		word[`SCSW_B_CTRLFLT]             = ctrl_flt_q;
		word[`SCSW_B_GENERIC]             = gen_q;
		word[`SCSW_B_IDRW]                = idrw_q;
		word[`SCSW_B_WPSKIP]              = wps_q;
		word[`SCSW_B_ECCOFF]              = ctrl_q[`SCSW_CTRL_ECCOFF];
		word[`SCSW_B_ERASERST]            = erst_q;
		word[`SCSW_B_ST_HI:`SCSW_B_ST_LO] = rx_state_q;
		word[`SCSW_B_RDY]                 = s_empty;
		word[`SCSW_B_SWITCH]              = sw_q;
		word[`SCSW_B_APP]                 = app_q;
		word[`SCSW_B_AUTH]                = auth_q;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			lockf_q    <= 1'b0;
			crc_q      <= 1'b0;
			ill_q      <= 1'b0;
			eccf_q     <= 1'b0;
			ctrl_flt_q <= 1'b0;
			gen_q      <= 1'b0;
			idrw_q     <= 1'b0;
			wps_q      <= 1'b0;
			erst_q     <= 1'b0;
			sw_q       <= 1'b0;
			app_q      <= 1'b0;
			auth_q     <= 1'b0;
			erpend_q   <= 1'b0;
		end else begin
			lockf_q    <= upd(lockf_q, lclk_rise & s_lockf, rd_clear);
			crc_q      <= upd(crc_q, ev_cmd & s_crc, cmd_clear);
			ill_q      <= upd(ill_q, ev_good & s_ill, cmd_clear);
			eccf_q     <= upd(eccf_q, lclk_rise & s_eccf, rd_clear);
			ctrl_flt_q <= upd(ctrl_flt_q, lclk_rise & s_ctrl, rd_clear);
			gen_q      <= upd(gen_q, lclk_rise & s_gen, rd_clear);
			idrw_q     <= upd(idrw_q, lclk_rise & s_idrw, rd_clear);
			wps_q      <= upd(wps_q, lclk_rise & s_wps, rd_clear);
			sw_q       <= upd(sw_q, lclk_rise & s_sw, cmd_clear);
			auth_q     <= upd(auth_q, lclk_rise & s_auth, rd_clear);
			app_q      <= upd(app_q, ev_good & (s_idx == `SCSW_CMD_APP), rd_clear);
			if (ev_good) begin
				if ((s_idx == `SCSW_CMD_ERSTART) | (s_idx == `SCSW_CMD_EREND)) begin
					erpend_q <= 1'b1;
				end else if (!erase_cmd) begin
					erpend_q <= 1'b0;
				end else if (s_idx == `SCSW_CMD_ERASE) begin
					erpend_q <= 1'b0;
				end
			end
			erst_q <= upd(erst_q, ev_good & erpend_q & ~erase_cmd, rd_clear);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_q <= 4'h0;
		end else if (ev_good) begin
			rx_state_q <= ctrl_q[`SCSW_CTRL_ST_HI:`SCSW_CTRL_ST_LO];
		end
	end

	// Response word loaded on the same edge as the state capture
	reg load_pend_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			load_pend_q <= 1'b0;
			resp_load   <= 1'b0;
			resp_word   <= 32'h0000_0000;
		end else begin
			load_pend_q <= ev_good;
			resp_load   <= 1'b0;
			if (ev_good) begin
				resp_word <= {word[31:13], ctrl_q[`SCSW_CTRL_ST_HI:`SCSW_CTRL_ST_LO],
					word[8:0]};
				resp_load <= 1'b1;
			end
		end
	end

	// AXI4-Lite write channel
	reg        aw_have_q;
	reg        w_have_q;
	reg [3:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;
	wire       wr_go;

	assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
	assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_addr_q    <= 4'h0;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SCSW_RESP_OK;
			ctrl_q       <= `SCSW_CTRL_RST;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_q == `SCSW_OFF_CTRL) begin
					ctrl_q      <= wmerge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_003f;
					s_axi_bresp <= `SCSW_RESP_OK;
				end else if ((aw_addr_q == `SCSW_OFF_STATUS) ||
						(aw_addr_q == `SCSW_OFF_RESP)) begin
					s_axi_bresp <= `SCSW_RESP_OK;
				end else begin
					s_axi_bresp <= `SCSW_RESP_SLVERR;
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SCSW_RESP_OK;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `SCSW_RESP_OK;
			if (s_axi_araddr == `SCSW_OFF_STATUS) begin
				s_axi_rdata <= word;
			end else if (s_axi_araddr == `SCSW_OFF_CTRL) begin
				s_axi_rdata <= ctrl_q;
			end else if (s_axi_araddr == `SCSW_OFF_RESP) begin
				s_axi_rdata <= resp_word;
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `SCSW_RESP_SLVERR;
			end
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: tb/scsw_link_model.sv
// Command source that frames one link clock per command
`timescale 1ns/10ps
module scsw_link_model (
	// Bench clock
	input  logic       aclk,
	// Link pins
	output logic       link_clk,
	output logic       cmd_valid,
	output logic [5:0] cmd_index,
	output logic [9:0] cmd_ev
);
	initial begin
		link_clk = 1'b0;
		cmd_valid = 1'b0;
		cmd_index = 6'h00;
		cmd_ev = 10'h000;
	end
	task automatic send(input logic [5:0] idx, input logic [9:0] ev);
		@(posedge aclk);
		cmd_valid <= 1'b1;
		cmd_index <= idx;
		cmd_ev    <= ev;
		// Half of the 160 ns link period
		repeat (20) @(posedge aclk);
		link_clk <= 1'b1;
		repeat (20) @(posedge aclk);
		link_clk <= 1'b0;
		repeat (5) @(posedge aclk);
		cmd_valid <= 1'b0;
		cmd_index <= ~idx;
		cmd_ev    <= 10'h000;
		repeat (20) @(posedge aclk);
	endtask
endmodule

// File: tb/scsw_status_asserts.sv
// Port checker for the card status word block
`timescale 1ns/10ps
module scsw_status_chk (
	// Clock, reset and bus
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	// Link side
	input wire        link_clk,
	input wire        cmd_valid,
	input wire        cmd_crc_bad,
	input wire [31:0] resp_word,
	input wire        resp_load
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence no_load2;
		!resp_load [*2];
	endsequence
	sequence good_rise;
		$rose(link_clk) && cmd_valid && !cmd_crc_bad;
	endsequence
	sequence load_soon;
		##[2:4] resp_load;
	endsequence
	rsvd_zero_a: assert property (resp_load |-> (resp_word & 32'hfc06_0057) == 32'h0)
		else $error("reserved response bits set");
	load_pulse_a: assert property (resp_load |=> !resp_load)
		else $error("response load longer than one cycle");
	word_hold_a: assert property (!resp_load |-> $stable(resp_word))
		else $error("response word changed without load");
	load_link_a: assert property (resp_load |-> link_clk)
		else $error("response load outside link high phase");
	rise_quiet_a: assert property ($rose(link_clk) |-> no_load2)
		else $error("response load too early after link rise");
	valid_load_a: assert property (good_rise |-> load_soon)
		else $error("no response load after valid command");
	rd_lat_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
endmodule

bind scsw_status scsw_status_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .link_clk, .cmd_valid,
	.cmd_crc_bad, .resp_word, .resp_load);

// File: tb/scsw_status_tb_top.sv
// Self-checking bench for the card status word block
`timescale 1ns/10ps
`include "scsw_defs.vh"
module scsw_status_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, buf_empty = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, got, b;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic [1:0]  rsp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         link_clk, cmd_valid, resp_load;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata, resp_word;
	wire [5:0]   cmd_index;
	wire [9:0]   ev;
	int          errors = 0, n_compared = 0, loads = 0, n;
	int          pos [10] = '{23, 22, 24, 21, 20, 19, 16, 15, 7, 3};
	always #2 aclk = ~aclk;
	always @(posedge aclk) if (resp_load === 1'b1) loads <= loads + 1;
	scsw_link_model u_link (.aclk, .link_clk, .cmd_valid, .cmd_index, .cmd_ev(ev));
	scsw_status DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .link_clk, .cmd_valid,
		.cmd_index, .cmd_crc_bad(ev[0]), .cmd_illegal(ev[1]), .lock_unlock_fail(ev[2]),
		.ecc_fail(ev[3]), .internal_ctrl_fault(ev[4]), .generic_fault(ev[5]),
		.id_spec_rewrite_fault(ev[6]), .wp_erase_skip(ev[7]), .switch_fail(ev[8]),
		.auth_seq_fault(ev[9]), .buf_empty, .resp_word, .resp_load);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (s_axi_bvalid !== 1'b1) begin
			errors++;
			$display("Error at %0t: write response timed out", $time);
			finish_test();
		end
		chk(s_axi_bresp, er);
	endtask
	task automatic axr(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (s_axi_rvalid !== 1'b1) begin
			errors++;
			$display("Error at %0t: read data timed out", $time);
			finish_test();
		end
		got = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic cmd(input logic [5:0] i, input logic [9:0] e, input logic [31:0] m, x);
		int l;
		l = loads;
		u_link.send(i, e);
		chk(resp_word & m, x);
		chk(loads - l, e[0] ? 0 : 1);
	endtask
	initial begin
		#200000;
		errors++;
		$display("Error at %0t: run timed out", $time);
		finish_test();
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(`SCSW_OFF_CTRL);
		chk(got, `SCSW_CTRL_RST);
		axr(4'hc);
		chk(rsp, `SCSW_RESP_SLVERR);
		axw(4'hc, 32'h1, `SCSW_RESP_SLVERR);
		axw(`SCSW_OFF_CTRL, 32'h0000_0013, `SCSW_RESP_OK);
		buf_empty <= 1'b1;
		cmd(6'h10, 0, 32'hffff_ffff, 32'h0200_4900);
		axw(`SCSW_OFF_CTRL, 32'h0000_001c, `SCSW_RESP_OK);
		buf_empty <= 1'b0;
		cmd(6'h10, 0, 32'hffff_ffff, 32'h0000_0e00);
		axr(`SCSW_OFF_RESP);
		chk(got, 32'h0000_0e00);
		$display("fields test done");
		b = 32'h1 << 23;
		cmd(6'h10, 10'h001, 0, 0);
		cmd(6'h10, 0, b, b);
		cmd(6'h10, 0, b, 0);
		for (int i = 1; i < 10; i++) begin
			b = 32'h1 << pos[i];
			cmd(6'h10, 10'h001 << i, b, 0);
			cmd(6'h10, 0, b, b);
			if (i == 1 || i == 8) begin
				cmd(6'h10, 0, b, 0);
			end else begin
				axr(`SCSW_OFF_STATUS);
				chk(got & b, b);
				axr(`SCSW_OFF_STATUS);
				chk(got & b, 0);
			end
		end
		$display("event test done");
		b = 32'h20;
		cmd(6'h37, 0, 0, 0);
		cmd(6'h10, 0, b, b);
		axr(`SCSW_OFF_STATUS);
		cmd(6'h10, 0, b, 0);
		b = 32'h1 << 13;
		cmd(6'h23, 0, 0, 0);
		cmd(6'h0d, 0, b, 0);
		cmd(6'h10, 0, b, 0);
		cmd(6'h0d, 0, b, b);
		cmd(6'h10, 0, b, 0);
		$display("prefix and erase test done");
		finish_test();
	end
endmodule
